// ---- design/fes_cfg.svh ----
// offsets, field values and timing counts of the init sequencer
//
// Summary of operation
// R01: accel stays suspended until initialization completes
// R02: host reruns whole sequence after every reset
// R03: first step clears advanced power save
// R04: wait at least 450 us after that
// R05: sensor time low byte ticks every 39.25 us
// R06: write init control 0x00, then load image
// R07: bursts even length, appended in order
// R08: image reads back through the feature window
// R09: enable write 0x01 at most once per reset
// R10: status message 0x1 within 150 ms, host polls
// R11: success leaves device in configuration mode
// R12: supply loss on either rail resets device
// R13: writes 1000 us apart under power save
// R14: host gives up polling after bounded timeout
`ifndef FES_CFG_SVH
`define FES_CFG_SVH

// device register offsets on the link
`define FES_REG_TIME0 8'h10
`define FES_REG_TIME1 8'h11
`define FES_REG_TIME2 8'h12
`define FES_REG_STATUS 8'h20
`define FES_REG_INIT_CTRL 8'h30
`define FES_REG_WINDOW 8'h31
`define FES_REG_PWR 8'h40
`define FES_REG_CMD 8'h41

// device field values
`define FES_PSAVE_ON 1'b1
`define FES_PSAVE_OFF 8'h00
`define FES_INIT_LOAD 8'h00
`define FES_INIT_ENABLE 8'h01
`define FES_SOFT_RESET 8'hA5
`define FES_MSG_NONE 4'h0
`define FES_MSG_OK 4'h1
`define FES_MSG_ERR 4'h2
`define FES_IMG_BYTES 1024
`define FES_IMG_WORDS 512
`define FES_BURST_LEN 16

// host wishbone register offsets
`define FES_WB_CTRL 8'h00
`define FES_WB_STATUS 8'h04
`define FES_WB_LEN 8'h08
`define FES_WB_IRQ_STAT 8'h0C
`define FES_WB_IRQ_CLR 8'h10
`define FES_WB_IRQ_EN 8'h14

// timing
`define FES_CLK_NS 50
`define FES_TICK_NS 39250
`define FES_TICK_CYC (`FES_TICK_NS / `FES_CLK_NS)
`define FES_PSAVE_WAIT_US 450
`define FES_PSAVE_WAIT_CYC ((`FES_PSAVE_WAIT_US * 1000 + `FES_CLK_NS - 1) / `FES_CLK_NS)
`define FES_WRITE_GAP_US 1000
`define FES_INIT_MS 140
`define FES_INIT_CYC ((`FES_INIT_MS * 1000000) / `FES_CLK_NS)
`define FES_TIMEOUT_MS 160
`define FES_TIMEOUT_CYC ((`FES_TIMEOUT_MS * 1000000) / `FES_CLK_NS)

`endif

// ---- design/fes_pkg.sv ----
// types shared by both ends of the init sequencer
package fes_pkg;
  typedef logic [7:0] fes_byte_t;
  typedef enum logic [3:0] {
    DEV_SUSPEND = 4'b0001,
    DEV_INIT = 4'b0010,
    DEV_READY = 4'b0100,
    DEV_FAIL = 4'b1000
  } fes_dev_state_t;
  typedef enum logic [7:0] {
    H_IDLE = 8'b00000001,
    H_PSAVE = 8'b00000010,
    H_WAIT = 8'b00000100,
    H_INIT0 = 8'b00001000,
    H_LOAD = 8'b00010000,
    H_VERIFY = 8'b00100000,
    H_ENABLE = 8'b01000000,
    H_POLL = 8'b10000000
  } fes_host_state_t;
endpackage

// ---- design/fes_link_if.sv ----
// byte register link between host controller and device
`timescale 1ns/100ps
interface fes_link_if;
  logic req;
  logic we;
  logic first;
  logic last;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  logic ack;
  modport host(output req, we, first, last, addr, wdata,
               input rdata, ack);
  modport dev(input req, we, first, last, addr, wdata,
              output rdata, ack);
endinterface

// ---- design/fes_device.sv ----
// device end: registers, image window, sensor time, init engine
`timescale 1ns/100ps
`include "fes_cfg.svh"
module fes_device #(
  parameter int INIT_CYC = `FES_INIT_CYC
) (
  input wire logic CLK_IN,
  input wire logic RST_N_IN,
  input wire logic VDD_OK_IN,
  input wire logic VDDIO_OK_IN,
  fes_link_if.dev LINK,
  output logic ACC_SUSPEND_OUT,
  output logic CONFIG_MODE_OUT,
  output logic FEATURES_READY_OUT,
  output logic ADV_PSAVE_OUT
);
  import fes_pkg::*;

  function automatic logic hit(input fes_byte_t a, input fes_byte_t r);
    hit = (a == r);
  endfunction

  logic [1:0] sup_in;
  logic [1:0] sup_ok;
  logic soft_rst_ff;
  logic rst;
  logic ack_ff;
  fes_byte_t rdata_ff;
  logic psave_ff;
  fes_byte_t init_ctrl_ff;
  fes_dev_state_t state_ff;
  logic [21:0] init_cnt_ff;
  logic [9:0] tick_ff;
  logic [23:0] time_ff;
  logic [15:0] img_mem [`FES_IMG_WORDS];
  logic [9:0] wptr_ff;
  logic [10:0] rptr_ff;
  fes_byte_t hold_ff;
  logic hold_vld_ff;
  logic odd_err_ff;
  logic [3:0] msg;
  fes_byte_t rd_mux;

  // supply monitors, four flops each
  assign sup_in = {VDDIO_OK_IN, VDD_OK_IN};
  genvar gi;
  generate
    for (gi = 0; gi < 2; gi++) begin : g_sync
      logic [2:0] sync_ff;
      logic ok_ff;
      always_ff @(posedge CLK_IN) begin
        if (!RST_N_IN) begin
          sync_ff <= 3'h0;
          ok_ff <= 1'b0;
        end else begin
          sync_ff <= {sync_ff[1:0], sup_in[gi]};
          if (sync_ff[1] == sync_ff[2]) begin
            ok_ff <= sync_ff[2];
          end
        end
      end
      assign sup_ok[gi] = ok_ff;
    end
  endgenerate

  // internal reset: pin, either rail low, or soft reset
  assign rst = !RST_N_IN || !(&sup_ok) || soft_rst_ff; // [R12]

  // access decode
  wire acc = LINK.req & ~ack_ff;
  wire wr = acc & LINK.we;
  wire rd = acc & ~LINK.we;
  wire wr_pwr = wr & hit(LINK.addr, `FES_REG_PWR);
  wire wr_init = wr & hit(LINK.addr, `FES_REG_INIT_CTRL);
  wire wr_win = wr & hit(LINK.addr, `FES_REG_WINDOW);
  wire wr_cmd = wr & hit(LINK.addr, `FES_REG_CMD);
  wire rd_win = rd & hit(LINK.addr, `FES_REG_WINDOW);
  wire wr_load = wr_init & (LINK.wdata == `FES_INIT_LOAD);
  wire wr_enable = wr_init & (LINK.wdata == `FES_INIT_ENABLE);
  wire [10:0] rd_idx = LINK.first ? 11'h000 : rptr_ff;
  wire [15:0] rd_word = img_mem[rd_idx[9:1]];
  wire fes_byte_t win_byte = rd_idx[0] ? rd_word[15:8] : rd_word[7:0];
  wire img_full = wptr_ff[9];

  // read data selection
  assign msg = (state_ff == DEV_READY) ? `FES_MSG_OK :
               (state_ff == DEV_FAIL) ? `FES_MSG_ERR : `FES_MSG_NONE;
  assign rd_mux =
    hit(LINK.addr, `FES_REG_TIME0) ? time_ff[7:0] :
    hit(LINK.addr, `FES_REG_TIME1) ? time_ff[15:8] :
    hit(LINK.addr, `FES_REG_TIME2) ? time_ff[23:16] :
    hit(LINK.addr, `FES_REG_STATUS) ? {3'h0, odd_err_ff, msg} :
    hit(LINK.addr, `FES_REG_INIT_CTRL) ? init_ctrl_ff :
    hit(LINK.addr, `FES_REG_PWR) ? {7'h00, psave_ff} :
    hit(LINK.addr, `FES_REG_WINDOW) ? win_byte : 8'h00; // [R08]

  // link answer, one cycle after request; survives soft reset
  always_ff @(posedge CLK_IN) begin
    if (!RST_N_IN) begin
      ack_ff <= 1'b0;
      rdata_ff <= 8'h00;
    end else begin
      ack_ff <= acc;
      if (rd) begin
        rdata_ff <= rd_mux;
      end
    end
  end

  // soft reset pulse from command write
  always_ff @(posedge CLK_IN) begin
    if (!RST_N_IN) begin
      soft_rst_ff <= 1'b0;
    end else begin
      soft_rst_ff <= wr_cmd & (LINK.wdata == `FES_SOFT_RESET);
    end
  end

  // sensor time, low byte steps every tick
  always_ff @(posedge CLK_IN) begin
    if (rst) begin
      tick_ff <= 10'h000;
      time_ff <= 24'h000000;
    end else if (tick_ff == 10'(`FES_TICK_CYC - 1)) begin
      tick_ff <= 10'h000;
      time_ff <= time_ff + 24'h000001; // [R05]
    end else begin
      tick_ff <= tick_ff + 10'h001;
    end
  end

  // power config and init control registers
  always_ff @(posedge CLK_IN) begin
    if (rst) begin
      psave_ff <= `FES_PSAVE_ON;
      init_ctrl_ff <= 8'h00;
    end else begin
      if (wr_pwr) begin
        psave_ff <= LINK.wdata[0];
      end
      if (wr_init) begin
        init_ctrl_ff <= LINK.wdata;
      end
    end
  end

  // image memory, written in byte pairs
  always_ff @(posedge CLK_IN) begin
    if (wr_win && hold_vld_ff && !img_full) begin
      img_mem[wptr_ff[8:0]] <= {LINK.wdata, hold_ff}; // [R07]
    end
  end

  // window pointers and pairing of burst bytes
  always_ff @(posedge CLK_IN) begin
    if (rst) begin
      wptr_ff <= 10'h000;
      rptr_ff <= 11'h000;
      hold_ff <= 8'h00;
      hold_vld_ff <= 1'b0;
      odd_err_ff <= 1'b0;
    end else begin
      if (wr_load) begin
        wptr_ff <= 10'h000; // [R06]
        hold_vld_ff <= 1'b0;
        odd_err_ff <= 1'b0;
      end else if (wr_win && state_ff == DEV_SUSPEND) begin
        if (hold_vld_ff) begin
          hold_vld_ff <= 1'b0;
          if (!img_full) begin
            wptr_ff <= wptr_ff + 10'h001; // [R07]
          end
        end else if (LINK.last) begin
          odd_err_ff <= 1'b1; // [R07]
        end else begin
          hold_ff <= LINK.wdata;
          hold_vld_ff <= 1'b1;
        end
      end
      if (rd_win) begin
        rptr_ff <= rd_idx + 11'h001; // [R08]
      end
    end
  end

  // feature engine start-up
  always_ff @(posedge CLK_IN) begin
    if (rst) begin
      state_ff <= DEV_SUSPEND; // [R01]
      init_cnt_ff <= 22'h000000;
    end else begin
      case (state_ff)
        DEV_SUSPEND: begin
          if (wr_enable) begin
            state_ff <= (wptr_ff == 10'h000) ? DEV_FAIL : DEV_INIT;
            init_cnt_ff <= 22'h000000;
          end
        end
        DEV_INIT: begin
          if (init_cnt_ff == 22'(INIT_CYC - 1)) begin
            state_ff <= DEV_READY; // [R10]
          end else begin
            init_cnt_ff <= init_cnt_ff + 22'h000001;
          end
        end
        DEV_READY: state_ff <= DEV_READY;
        DEV_FAIL: state_ff <= DEV_FAIL;
        default: state_ff <= DEV_SUSPEND;
      endcase
    end
  end

  // mode outputs
  assign ACC_SUSPEND_OUT = (state_ff != DEV_READY); // [R01]
  assign FEATURES_READY_OUT = (state_ff == DEV_READY);
  assign CONFIG_MODE_OUT = FEATURES_READY_OUT & ~psave_ff; // [R11]
  assign ADV_PSAVE_OUT = psave_ff;
  assign LINK.ack = ack_ff;
  assign LINK.rdata = rdata_ff;
endmodule

// ---- design/fes_host.sv ----
// host end: wishbone-controlled initialization sequencer
//
// Local design decisions: the Wishbone register port and the register offsets.
`timescale 1ns/100ps
`include "fes_cfg.svh"
module fes_host #(
  parameter int PSAVE_WAIT_CYC = `FES_PSAVE_WAIT_CYC,
  parameter int TIMEOUT_CYC = `FES_TIMEOUT_CYC
) (
  input wire logic CLK_IN,
  input wire logic RST_N_IN,
  input wire logic WB_CYC_IN,
  input wire logic WB_STB_IN,
  input wire logic WB_WE_IN,
  input wire logic [7:0] WB_ADR_IN,
  input wire logic [31:0] WB_DAT_IN,
  input wire logic [3:0] WB_SEL_IN,
  output logic [31:0] WB_DAT_OUT,
  output logic WB_ACK_OUT,
  output logic IRQ_OUT,
  output logic [10:0] IMG_ADDR_OUT,
  input wire fes_pkg::fes_byte_t IMG_DATA_IN,
  fes_link_if.host LINK
);
  import fes_pkg::*;

  function automatic logic wb_hit(input logic [7:0] a,
                                  input logic [7:0] r);
    wb_hit = (a == r);
  endfunction

  fes_host_state_t state_ff;
  logic wb_ack_ff;
  logic [31:0] wb_dat_ff;
  logic verify_en_ff;
  logic [10:0] len_ff;
  logic busy_ff;
  logic done_ff;
  logic fail_ff;
  logic verr_ff;
  logic tmo_ff;
  logic enabled_once_ff;
  logic [3:0] msg_ff;
  logic [1:0] irq_stat_ff;
  logic [1:0] irq_en_ff;
  logic [21:0] wait_ff;
  logic [10:0] cnt_ff;
  logic [4:0] burst_ff;
  logic req_ff;
  logic we_ff;
  logic first_ff;
  logic last_ff;
  fes_byte_t addr_ff;
  fes_byte_t wdata_ff;

  // wishbone decode
  wire wb_req = WB_CYC_IN & WB_STB_IN & ~wb_ack_ff;
  wire wb_wr = wb_req & WB_WE_IN & WB_SEL_IN[0];
  wire wr_ctrl = wb_wr & wb_hit(WB_ADR_IN, `FES_WB_CTRL);
  wire wr_len = wb_wr & wb_hit(WB_ADR_IN, `FES_WB_LEN);
  wire wr_clr = wb_wr & wb_hit(WB_ADR_IN, `FES_WB_IRQ_CLR);
  wire wr_en = wb_wr & wb_hit(WB_ADR_IN, `FES_WB_IRQ_EN);
  wire start = wr_ctrl & WB_DAT_IN[0] & (state_ff == H_IDLE) & ~req_ff;
  wire rearm = wr_ctrl & WB_DAT_IN[2];

  // state flags
  wire s_psave = (state_ff == H_PSAVE);
  wire s_init0 = (state_ff == H_INIT0);
  wire s_load = (state_ff == H_LOAD);
  wire s_verify = (state_ff == H_VERIFY);
  wire s_enable = (state_ff == H_ENABLE);
  wire s_poll = (state_ff == H_POLL);
  wire s_issue = s_psave | s_init0 | s_load | s_verify | s_enable | s_poll;
  wire issue = s_issue & ~req_ff;
  wire got = LINK.ack & req_ff;
  wire last_byte = (cnt_ff == len_ff - 11'h001);
  wire burst_end = (burst_ff == 5'(`FES_BURST_LEN - 1)) | last_byte;
  wire wait_done = (wait_ff == 22'(PSAVE_WAIT_CYC - 1));
  wire tmo_hit = (wait_ff == 22'(TIMEOUT_CYC - 1));
  wire [3:0] rx_msg = LINK.rdata[3:0];
  wire mism = (LINK.rdata != IMG_DATA_IN);

  // events of the sequence
  wire done_ev = s_poll & got & (rx_msg == `FES_MSG_OK); // [R10]
  wire fail_poll = s_poll & ~done_ev &
                   ((got & (rx_msg == `FES_MSG_ERR)) | tmo_hit); // [R14]
  wire fail_ver = s_verify & got & mism; // [R08]
  wire fail_once = start & enabled_once_ff; // [R09]
  wire fail_ev = fail_poll | fail_ver | fail_once;

  // next link request of the current step
  wire fes_byte_t op_addr =
    s_psave ? `FES_REG_PWR :
    (s_init0 | s_enable) ? `FES_REG_INIT_CTRL :
    (s_load | s_verify) ? `FES_REG_WINDOW : `FES_REG_STATUS;
  wire fes_byte_t op_wdata =
    s_psave ? `FES_PSAVE_OFF : // [R03]
    s_init0 ? `FES_INIT_LOAD : // [R06]
    s_enable ? `FES_INIT_ENABLE : IMG_DATA_IN;
  wire op_we = ~(s_verify | s_poll);
  wire op_first = s_load ? (burst_ff == 5'h00) : (cnt_ff == 11'h000);
  wire op_last = (s_load & burst_end) | (s_verify & last_byte); // [R07]

  // link request registers, held until answered
  always_ff @(posedge CLK_IN) begin
    if (!RST_N_IN) begin
      req_ff <= 1'b0;
      we_ff <= 1'b0;
      first_ff <= 1'b0;
      last_ff <= 1'b0;
      addr_ff <= 8'h00;
      wdata_ff <= 8'h00;
    end else if (issue) begin
      req_ff <= 1'b1;
      we_ff <= op_we;
      first_ff <= op_first;
      last_ff <= op_last;
      addr_ff <= op_addr;
      wdata_ff <= op_wdata;
    end else if (LINK.ack) begin
      req_ff <= 1'b0;
    end
  end

  // sequence state machine
  always_ff @(posedge CLK_IN) begin
    if (!RST_N_IN) begin
      state_ff <= H_IDLE;
      wait_ff <= 22'h000000;
      cnt_ff <= 11'h000;
      burst_ff <= 5'h00;
    end else begin
      case (state_ff)
        H_IDLE: begin
          if (start && !enabled_once_ff) begin
            state_ff <= H_PSAVE; // [R02]
          end
        end
        H_PSAVE: begin
          if (got) begin
            state_ff <= H_WAIT;
            wait_ff <= 22'h000000;
          end
        end
        H_WAIT: begin
          // the clearing write is the only one under power save
          wait_ff <= wait_ff + 22'h000001; // [R13]
          if (wait_done) begin
            state_ff <= H_INIT0; // [R04]
          end
        end
        H_INIT0: begin
          if (got) begin
            state_ff <= (len_ff == 11'h000) ? H_ENABLE : H_LOAD;
            cnt_ff <= 11'h000;
            burst_ff <= 5'h00;
          end
        end
        H_LOAD: begin
          if (got) begin
            cnt_ff <= cnt_ff + 11'h001;
            burst_ff <= last_ff ? 5'h00 : burst_ff + 5'h01; // [R07]
            if (last_byte) begin
              state_ff <= verify_en_ff ? H_VERIFY : H_ENABLE;
              cnt_ff <= 11'h000;
            end
          end
        end
        H_VERIFY: begin
          if (fail_ver) begin
            state_ff <= H_IDLE;
          end else if (got) begin
            cnt_ff <= cnt_ff + 11'h001;
            if (last_byte) begin
              state_ff <= H_ENABLE; // [R08]
            end
          end
        end
        H_ENABLE: begin
          if (got) begin
            state_ff <= H_POLL; // [R09]
            wait_ff <= 22'h000000;
          end
        end
        H_POLL: begin
          wait_ff <= wait_ff + 22'h000001;
          if (done_ev || fail_poll) begin
            state_ff <= H_IDLE; // [R10]
          end
        end
        default: state_ff <= H_IDLE;
      endcase
    end
  end

  // status flags and the once-only enable guard
  always_ff @(posedge CLK_IN) begin
    if (!RST_N_IN) begin
      busy_ff <= 1'b0;
      done_ff <= 1'b0;
      fail_ff <= 1'b0;
      verr_ff <= 1'b0;
      tmo_ff <= 1'b0;
      enabled_once_ff <= 1'b0;
      msg_ff <= 4'h0;
    end else begin
      if (start) begin
        busy_ff <= ~enabled_once_ff;
        done_ff <= 1'b0;
        fail_ff <= 1'b0;
        verr_ff <= 1'b0;
        tmo_ff <= 1'b0;
      end
      if (done_ev || fail_ev) begin
        busy_ff <= 1'b0;
        done_ff <= done_ev;
        fail_ff <= fail_ev;
      end
      if (fail_ver) begin
        verr_ff <= 1'b1;
      end
      if (s_poll && tmo_hit && !done_ev) begin
        tmo_ff <= 1'b1; // [R14]
      end
      if (s_poll && got) begin
        msg_ff <= rx_msg;
      end
      if (s_enable && got) begin
        enabled_once_ff <= 1'b1; // [R09]
      end else if (rearm) begin
        enabled_once_ff <= 1'b0; // [R02]
      end
    end
  end

  // software registers and interrupt status; set beats clear
  always_ff @(posedge CLK_IN) begin
    if (!RST_N_IN) begin
      verify_en_ff <= 1'b0;
      len_ff <= 11'h000;
      irq_en_ff <= 2'h0;
      irq_stat_ff <= 2'h0;
    end else begin
      if (wr_ctrl) begin
        verify_en_ff <= WB_DAT_IN[1];
      end
      if (wr_len) begin
        len_ff <= {WB_DAT_IN[10:1], 1'b0}; // [R07]
      end
      if (wr_en) begin
        irq_en_ff <= WB_DAT_IN[1:0];
      end
      irq_stat_ff <= (irq_stat_ff & ~(wr_clr ? WB_DAT_IN[1:0] : 2'h0)) |
                     {fail_ev, done_ev};
    end
  end

  // wishbone read data
  wire [31:0] status_word = {20'h00000, msg_ff, 2'h0, enabled_once_ff,
                             tmo_ff, verr_ff, fail_ff, done_ff, busy_ff};
  wire [31:0] rd_mux =
    wb_hit(WB_ADR_IN, `FES_WB_CTRL) ? {30'h0, verify_en_ff, 1'b0} :
    wb_hit(WB_ADR_IN, `FES_WB_STATUS) ? status_word :
    wb_hit(WB_ADR_IN, `FES_WB_LEN) ? {21'h000000, len_ff} :
    wb_hit(WB_ADR_IN, `FES_WB_IRQ_STAT) ? {30'h0, irq_stat_ff} :
    wb_hit(WB_ADR_IN, `FES_WB_IRQ_EN) ? {30'h0, irq_en_ff} : 32'h0;

  // wishbone answer one cycle after the strobe
  always_ff @(posedge CLK_IN) begin
    if (!RST_N_IN) begin
      wb_ack_ff <= 1'b0;
      wb_dat_ff <= 32'h00000000;
    end else begin
      wb_ack_ff <= wb_req;
      if (wb_req && !WB_WE_IN) begin
        wb_dat_ff <= rd_mux;
      end
    end
  end

  // outputs
  assign WB_ACK_OUT = wb_ack_ff;
  assign WB_DAT_OUT = wb_dat_ff;
  assign IRQ_OUT = |(irq_stat_ff & irq_en_ff);
  assign IMG_ADDR_OUT = cnt_ff;
  assign LINK.req = req_ff;
  assign LINK.we = we_ff;
  assign LINK.first = first_ff;
  assign LINK.last = last_ff;
  assign LINK.addr = addr_ff;
  assign LINK.wdata = wdata_ff;
endmodule

// ---- sim/fes_init_asserts.sv ----
// link protocol and init sequence checks between host and device
`timescale 1ns/100ps
`include "fes_cfg.svh"
module fes_init_asserts #(
  parameter int PSAVE_WAIT_CYC = 20
) (
  input wire logic CLK_IN,
  input wire logic RST_N_IN,
  input wire logic req,
  input wire logic we,
  input wire logic first,
  input wire logic last,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic [7:0] rdata,
  input wire logic ack
);
  default clocking cb @(posedge CLK_IN);
  endclocking
  default disable iff (!RST_N_IN);
  // decode of the request being held on the link
  wire tk = req && !ack;
  wire wr_pwr = req && we && addr == `FES_REG_PWR;
  wire wr_init = req && we && addr == `FES_REG_INIT_CTRL;
  wire wr_en = wr_init && wdata == `FES_INIT_ENABLE;
  wire wr_win = req && we && addr == `FES_REG_WINDOW;
  logic [15:0] gap_ff;
  logic psv_ff;
  logic en_ff;
  logic par_ff;
  logic load_ff;
  // sequence history; the gap counter steps every cycle until it saturates, the rest updates only at answered writes
  always_ff @(posedge CLK_IN) begin
    if (!RST_N_IN) begin
      gap_ff <= 16'h0000;
      psv_ff <= 1'b0;
      en_ff <= 1'b0;
      par_ff <= 1'b0;
      load_ff <= 1'b0;
    end else begin
      gap_ff <= (ack && wr_pwr) ? 16'h0000 : gap_ff + {15'h0000, ~&gap_ff};
      if (ack && we) psv_ff <= wr_pwr;
      if (ack && (wr_en || wr_pwr)) en_ff <= wr_en;
      if (ack && wr_win) par_ff <= first ? 1'b1 : ~par_ff;
      if (ack && wr_init) load_ff <= wdata == `FES_INIT_LOAD;
    end
  end
  property p_ack_next;
    tk |=> ack;
  endproperty
  a_ack_next: assert property (p_ack_next)
    else $error("link request not answered in the next cycle");
  property p_req_hold;
    tk |=> req && $stable(addr) && $stable(we) && $stable(wdata);
  endproperty
  a_req_hold: assert property (p_req_hold)
    else $error("link request changed before its answer");
  property p_req_drop;
    ack |=> !req ##1 !ack;
  endproperty
  a_req_drop: assert property (p_req_drop)
    else $error("link request not released after its answer");
  property p_no_ack_idle;
    !req |=> !ack;
  endproperty
  a_no_ack_idle: assert property (p_no_ack_idle)
    else $error("link answer without a request");
  property p_psave_off;
    tk && wr_pwr |-> wdata == `FES_PSAVE_OFF;
  endproperty
  a_psave_off: assert property (p_psave_off)
    else $error("power config write does not clear power save");
  property p_psave_gap;
    tk && we && psv_ff |-> gap_ff >= PSAVE_WAIT_CYC - 1;
  endproperty
  a_psave_gap: assert property (p_psave_gap)
    else $error("write too soon after clearing power save");
  property p_en_once;
    tk && wr_en |-> !en_ff;
  endproperty
  a_en_once: assert property (p_en_once)
    else $error("second enable write in one sequence");
  property p_burst_even;
    tk && wr_win && last |-> !first && par_ff;
  endproperty
  a_burst_even: assert property (p_burst_even)
    else $error("window burst with odd byte count");
  property p_win_after_init;
    tk && wr_win |-> load_ff;
  endproperty
  a_win_after_init: assert property (p_win_after_init)
    else $error("window write before init control load");
  property p_en_poll;
    ack && wr_en |-> ##[1:3] (tk && !we && addr == `FES_REG_STATUS);
  endproperty
  a_en_poll: assert property (p_en_poll)
    else $error("status poll does not follow enable write");
endmodule

// ---- sim/test_feature_engine_init_sequencer.sv ----
// self-checking bench for host sequencer and device end
`timescale 1ns/100ps
`include "fes_cfg.svh"
module test_feature_engine_init_sequencer;
  import fes_pkg::*;
  localparam int INIT = 50;
  localparam int LIMIT = 20000;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic wbwe = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] dat = 32'h00000000;
  logic [3:0] sel = 4'h0;
  logic [31:0] wb_out;
  logic [31:0] wb_q;
  logic [7:0] lq;
  logic [7:0] t0;
  logic ack, irq, susp, cfg, rdy, psv;
  logic vdd_ok = 1'b1;
  logic vddio_ok = 1'b1;
  logic [10:0] img_addr;
  logic [10:0] len;
  fes_byte_t img_key = 8'h00;
  fes_byte_t b [4];
  int n_errors = 0;
  int checks = 0;
  int ncyc = 0;
  fes_link_if link();
  fes_link_if l2();
  // design ends facing each other, plus a second device driven directly over its own link
  fes_device #(.INIT_CYC(INIT)) i_fes_device (.CLK_IN(clk),
    .RST_N_IN(rst_n), .VDD_OK_IN(vdd_ok), .VDDIO_OK_IN(vddio_ok),
    .LINK(link), .ACC_SUSPEND_OUT(susp), .CONFIG_MODE_OUT(cfg),
    .FEATURES_READY_OUT(rdy), .ADV_PSAVE_OUT(psv));
  fes_device #(.INIT_CYC(INIT)) i_fes_device2 (.CLK_IN(clk),
    .RST_N_IN(rst_n), .VDD_OK_IN(vdd_ok), .VDDIO_OK_IN(vddio_ok),
    .LINK(l2), .ACC_SUSPEND_OUT(), .CONFIG_MODE_OUT(),
    .FEATURES_READY_OUT(), .ADV_PSAVE_OUT());
  fes_host #(.PSAVE_WAIT_CYC(20), .TIMEOUT_CYC(200)) i_fes_host (
    .CLK_IN(clk), .RST_N_IN(rst_n), .WB_CYC_IN(cyc), .WB_STB_IN(stb),
    .WB_WE_IN(wbwe), .WB_ADR_IN(adr), .WB_DAT_IN(dat), .WB_SEL_IN(sel),
    .WB_DAT_OUT(wb_out), .WB_ACK_OUT(ack), .IRQ_OUT(irq),
    .IMG_ADDR_OUT(img_addr), .IMG_DATA_IN(img_addr[7:0] ^ img_key),
    .LINK(link));
  fes_init_asserts #(.PSAVE_WAIT_CYC(20)) i_fes_init_asserts (
    .CLK_IN(clk), .RST_N_IN(rst_n), .req(link.req), .we(link.we),
    .first(link.first), .last(link.last), .addr(link.addr),
    .wdata(link.wdata), .rdata(link.rdata), .ack(link.ack));
  always #25 clk = ~clk;
  // run limit against hangs
  always @(posedge clk) begin
    ncyc++;
    if (ncyc == LIMIT) begin
      n_errors++;
      $display("timeout after %0d cycles", ncyc);
      final_report();
    end
  end
  task automatic final_report;
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, g);
    checks++;
    if (g !== e) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  // one classic wishbone cycle, held until ack is sampled
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [31:0] d);
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    wbwe <= w;
    adr <= a;
    dat <= d;
    sel <= 4'hF;
    do @(posedge clk); while (ack !== 1'b1);
    wb_q = wb_out;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  // one transfer on the second link, driven in the host's place
  task automatic lx(input logic w, f, l, input logic [7:0] a, d);
    @(posedge clk);
    l2.req <= 1'b1;
    l2.we <= w;
    l2.first <= f;
    l2.last <= l;
    l2.addr <= a;
    l2.wdata <= d;
    do @(posedge clk); while (l2.ack !== 1'b1);
    lq = l2.rdata;
    l2.req <= 1'b0;
    l2.wdata <= ~d;
  endtask
  task automatic wait_irq;
    while (irq !== 1'b1) @(posedge clk);
  endtask
  function automatic logic [31:0] exp_stat(input logic d, f,
                                           input logic [3:0] m);
    return {20'h00000, m, 3'b001, 2'b00, f, d, 1'b0};
  endfunction
  // main sequence
  initial begin
    l2.req = 1'b0;
    l2.we = 1'b0;
    l2.first = 1'b0;
    l2.last = 1'b0;
    l2.addr = 8'h00;
    l2.wdata = 8'h00;
    void'($urandom(32'h49CE));
    img_key = 8'($urandom);
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (6) @(posedge clk);
    chk("suspend", 1, susp);
    chk("psave", 1, psv);
    wb(0, `FES_WB_STATUS, 0);
    chk("status", 0, wb_q);
    wb(0, 8'h18, 0);
    chk("unmapped", 0, wb_q);
    $display("test reset done");
    len = 11'($urandom_range(40, 8)) | 11'h001;
    wb(1, `FES_WB_LEN, {21'h0, len});
    wb(0, `FES_WB_LEN, 0);
    chk("len", {21'h0, len & 11'h7FE}, wb_q);
    wb(1, `FES_WB_IRQ_EN, 3);
    wb(1, `FES_WB_CTRL, 3);
    wait_irq();
    wb(0, `FES_WB_STATUS, 0);
    chk("status", exp_stat(1, 0, 1), wb_q);
    chk("ready", 1, rdy);
    chk("config", 1, cfg);
    chk("suspend", 0, susp);
    chk("psave", 0, psv);
    wb(1, `FES_WB_IRQ_CLR, 1);
    repeat (2) @(posedge clk);
    chk("irq", 0, irq);
    $display("test init done");
    wb(1, `FES_WB_IRQ_EN, 1);
    wb(1, `FES_WB_CTRL, 1);
    repeat (4) @(posedge clk);
    chk("masked irq", 0, irq);
    wb(0, `FES_WB_IRQ_STAT, 0);
    chk("irq stat", 2, wb_q);
    wb(0, `FES_WB_STATUS, 0);
    chk("fail", 1, wb_q[2]);
    wb(1, `FES_WB_IRQ_EN, 2);
    repeat (2) @(posedge clk);
    chk("irq", 1, irq);
    wb(1, `FES_WB_IRQ_CLR, 3);
    repeat (2) @(posedge clk);
    chk("irq", 0, irq);
    wb(1, `FES_WB_CTRL, 4);
    wb(0, `FES_WB_STATUS, 0);
    chk("rearm", 0, wb_q[5]);
    $display("test second enable done");
    for (int r = 0; r < 2; r++) begin
      {vdd_ok, vddio_ok} <= r ? 2'b10 : 2'b01;
      repeat (6) @(posedge clk);
      chk("rail suspend", 1, susp);
      chk("rail ready", 0, rdy);
      {vdd_ok, vddio_ok} <= 2'b11;
      repeat (6) @(posedge clk);
    end
    $display("test rails done");
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    repeat (6) @(posedge clk);
    chk("suspend", 1, susp);
    wb(0, `FES_WB_STATUS, 0);
    chk("status", 0, wb_q);
    wb(1, `FES_WB_LEN, 0);
    wb(1, `FES_WB_IRQ_EN, 2);
    wb(1, `FES_WB_CTRL, 1);
    wait_irq();
    wb(0, `FES_WB_STATUS, 0);
    chk("status", exp_stat(0, 1, 2), wb_q);
    $display("test empty image done");
    lx(1, 0, 0, `FES_REG_INIT_CTRL, `FES_INIT_LOAD);
    lx(1, 1, 0, `FES_REG_WINDOW, 8'h11);
    lx(1, 0, 0, `FES_REG_WINDOW, 8'h22);
    lx(1, 0, 1, `FES_REG_WINDOW, 8'h33);
    lx(0, 0, 0, `FES_REG_STATUS, 8'h00);
    chk("odd burst", 8'h10, lq);
    lx(1, 0, 0, `FES_REG_INIT_CTRL, `FES_INIT_LOAD);
    for (int i = 0; i < 4; i++) begin
      b[i] = 8'($urandom);
      lx(1, i % 2 == 0, i % 2 == 1, `FES_REG_WINDOW, b[i]);
    end
    for (int i = 0; i < 4; i++) begin
      lx(0, i == 0, 0, `FES_REG_WINDOW, 8'h00);
      chk("readback", b[i], lq);
    end
    lx(1, 0, 0, `FES_REG_INIT_CTRL, `FES_INIT_ENABLE);
    repeat (INIT + 10) @(posedge clk);
    lx(0, 0, 0, `FES_REG_STATUS, 8'h00);
    chk("msg", 8'h01, lq);
    lx(0, 0, 0, `FES_REG_TIME0, 8'h00);
    t0 = lq;
    repeat (`FES_TICK_CYC - 3) @(posedge clk);
    lx(0, 0, 0, `FES_REG_TIME0, 8'h00);
    chk("time tick", 8'(t0 + 8'h01), lq);
    lx(1, 0, 0, `FES_REG_CMD, `FES_SOFT_RESET);
    lx(0, 0, 0, `FES_REG_STATUS, 8'h00);
    chk("soft reset", 8'h00, lq);
    $display("test link done");
    final_report();
  end
endmodule
